/* File: src/sbm_ctrl.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "sbm_params.svh"
module sbm_ctrl #(
  parameter int SAMPLE_CYC = `SBM_SAMPLE_CYC
) (
  // Clock and asynchronous active-low reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Nonvolatile memory user row word.
  input wire logic [31:0] nvm_cfg,
  input wire logic nvm_valid,
  // Sleep mode indications.
  input wire logic standby_mode,
  input wire logic backup_mode,
  // Prescaler clock, about 1 kHz, from the low-power oscillator.
  input wire logic prescaler_clk,
  // Main supply comparator.
  input wire logic main_below,
  input wire logic main_ready,
  output logic det_enable,
  output logic [5:0] det_level,
  output logic det_use_backup,
  output logic det_monitor_sel,
  // Core supply comparator and ready inputs.
  input wire logic core_below,
  input wire logic core_voltage_ready_in,
  input wire logic power_switch_ready_in,
  input wire logic regulator_ready_in,
  output logic core_det_enable,
  // System actions.
  output logic sys_reset_req,
  output logic power_switch_req,
  output logic irq,
  output logic cfg_loaded
);

  //============================================================
  // State and helpers
  //============================================================

  // Registered state and its next value.
  sbm_pkg::sbm_st_t s_r;
  sbm_pkg::sbm_st_t s_nxt;
  // Sampling mode selected for the present sleep mode.
  logic sampling;
  // One bus clock pulse per sampling tick.
  logic tick;
  // Edge of the synchronised prescaler clock.
  logic pre_rise;
  // Ready inputs gathered for edge detection.
  logic [3:0] rdy_now;
  // Rising edges of the ready inputs.
  logic [3:0] rdy_rise;
  // Flag bits raised by hardware this cycle.
  logic [`SBM_IRQ_W-1:0] flag_set;
  // Write decode strobes.
  logic wr_clr;
  logic wr_set;
  logic wr_flag;
  logic wr_cfg;
  // Word returned for a read.
  logic [31:0] rd_word;
  // Measure window completes in this cycle.
  logic smp_done;

  // Terminal count of the tick divider for a prescaler select.
  // The one-hot word is one bit wider than the counter so that select 15 still fits.
  function automatic logic [`SBM_DIV_W-1:0] div_last(input logic [3:0] psel);
    logic [`SBM_DIV_W:0] one_hot;
    one_hot = '0;
    one_hot[psel + 5'd1] = 1'b1;
    div_last = one_hot[`SBM_DIV_W-1:0] - 17'h0_0001;
  endfunction

  // Register address match for a write or read.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  //============================================================
  // Combinational decode
  //============================================================

  // Decoding of strobes, modes and hardware events.
  always_comb begin
    wr_clr = reg_wr && hit(reg_addr, `SBM_OFS_IEN_CLR);
    wr_set = reg_wr && hit(reg_addr, `SBM_OFS_IEN_SET);
    wr_flag = reg_wr && hit(reg_addr, `SBM_OFS_FLAG);
    wr_cfg = reg_wr && hit(reg_addr, `SBM_OFS_CFG);
    // The sample bit of the present mode picks sampling.
    sampling = standby_mode ? s_r.cfg.standby_sample_cfg : s_r.cfg.active_sample_cfg;
    // The second synchroniser stage is compared with its delayed copy pre_q here.
    pre_rise = s_r.pre_s2 && !s_r.pre_q;
    // Tick after two to the power psel+1 prescaler edges.
    // Lowering the select mid-count must not wait for the counter to wrap.
    tick = pre_rise && (s_r.div >= div_last(s_r.cfg.sample_prescaler_select));
    smp_done = (s_r.smp == 4'(SAMPLE_CYC - 1));
    rdy_now = {core_voltage_ready_in, power_switch_ready_in, regulator_ready_in, main_ready};
    rdy_rise = rdy_now & ~s_r.rdy_q;
    flag_set = '0;
    flag_set[`SBM_IRQ_BOD_RDY] = rdy_rise[0];
    flag_set[`SBM_IRQ_VREG_RDY] = rdy_rise[1];
    flag_set[`SBM_IRQ_APWS_RDY] = rdy_rise[2];
    flag_set[`SBM_IRQ_VCORE_RDY] = rdy_rise[3];
    flag_set[`SBM_IRQ_SYNC_RDY] = s_r.srdy_p;
    // The detected flag is raised in the next-state logic, where the new result is known.
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_word = '0;
    unique case (reg_addr)
      `SBM_OFS_IEN_CLR,
      `SBM_OFS_IEN_SET: begin
        // Both views show the same enables.
        rd_word[`SBM_IRQ_W-1:0] = s_r.ien;
      end
      `SBM_OFS_FLAG: begin
        rd_word[`SBM_IRQ_W-1:0] = s_r.flag;
      end
      `SBM_OFS_STATUS: begin
        // Live detection result and ready levels.
        rd_word[`SBM_IRQ_DET] = s_r.det;
        rd_word[`SBM_IRQ_BOD_RDY] = s_r.rdy_q[0];
        rd_word[`SBM_IRQ_VREG_RDY] = s_r.rdy_q[1];
        rd_word[`SBM_IRQ_APWS_RDY] = s_r.rdy_q[2];
        rd_word[`SBM_IRQ_VCORE_RDY] = s_r.rdy_q[3];
      end
      `SBM_OFS_CFG: begin
        rd_word = s_r.cfg;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  //============================================================
  // Next state
  //============================================================

  // All state advances here; the register below only stores it.
  always_comb begin
    s_nxt = s_r;
    s_nxt.pre_s1 = prescaler_clk;
    s_nxt.pre_s2 = s_r.pre_s1;
    s_nxt.pre_q = s_r.pre_s2;
    s_nxt.rdy_q = rdy_now;
    s_nxt.srdy_p = 1'b0;
    // Prescaler edges count towards the next sampling tick.
    if (pre_rise) begin
      s_nxt.div = tick ? '0 : s_r.div + 17'h0_0001;
    end
    unique case (s_r.fsm)
      sbm_pkg::SBM_LOAD: begin
        // Settings come from the user row once it is valid.
        if (nvm_valid) begin
          s_nxt.cfg = sbm_pkg::sbm_cfg_t'(nvm_cfg & `SBM_CFG_MASK);
          s_nxt.fsm = sbm_pkg::SBM_CONT;
        end
      end
      sbm_pkg::SBM_CONT: begin
        // Continuous unless a sample bit says otherwise.
        if (sampling) begin
          s_nxt.fsm = sbm_pkg::SBM_OFF;
        end else if (s_r.cfg.enable && main_ready) begin
          s_nxt.det = main_below;
        end
      end
      sbm_pkg::SBM_OFF: begin
        // Detector rests between ticks; result is held.
        if (!sampling) begin
          s_nxt.fsm = sbm_pkg::SBM_CONT;
        end else if (tick) begin
          s_nxt.fsm = sbm_pkg::SBM_ON;
          s_nxt.smp = '0;
        end
      end
      sbm_pkg::SBM_ON: begin
        // Short measure window, result taken at its end.
        if (!sampling) begin
          s_nxt.fsm = sbm_pkg::SBM_CONT;
        end else if (smp_done) begin
          s_nxt.fsm = sbm_pkg::SBM_OFF;
          if (main_ready) begin
            s_nxt.det = main_below;
          end
        end else begin
          s_nxt.smp = s_r.smp + 4'h1;
        end
      end
    endcase
    // A disabled detector reports no brown-out.
    if (!s_r.cfg.enable || s_r.fsm == sbm_pkg::SBM_LOAD) begin
      s_nxt.det = 1'b0;
    end
    // Software configuration write, ignored while loading.
    if (wr_cfg && s_r.fsm != sbm_pkg::SBM_LOAD) begin
      s_nxt.cfg = sbm_pkg::sbm_cfg_t'(reg_wdata & `SBM_CFG_MASK);
      s_nxt.srdy_p = 1'b1;
    end
    // The power switch stays engaged until the supply recovers.
    // Battery monitoring never engages it.
    // The new settings decide, so a switch to battery never leaks one cycle.
    s_nxt.psw = s_nxt.det && !s_nxt.cfg.monitor_select &&
                (s_nxt.cfg.brownout_action == sbm_pkg::SBM_ACT_PSW);
    // Enables: set writes OR, clear writes remove ones.
    if (wr_set) begin
      s_nxt.ien = s_r.ien | (reg_wdata[`SBM_IRQ_W-1:0] & `SBM_IRQ_MASK);
    end
    if (wr_clr) begin
      s_nxt.ien = s_r.ien & ~reg_wdata[`SBM_IRQ_W-1:0];
    end
    // Flags clear on a written one, but a new event wins.
    s_nxt.flag = s_r.flag;
    if (wr_flag) begin
      s_nxt.flag = s_r.flag & ~reg_wdata[`SBM_IRQ_W-1:0];
    end
    s_nxt.flag = s_nxt.flag | flag_set;
    // A new detection raises the detected flag.
    s_nxt.flag[`SBM_IRQ_DET] = s_nxt.flag[`SBM_IRQ_DET] | (s_nxt.det && !s_r.det);
    // Read data stands in the cycle after the strobe only.
    s_nxt.rdata = reg_rd ? rd_word : '0;
  end

  //============================================================
  // State register
  //============================================================

  // Reset places constants only; the load happens after release.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.fsm <= sbm_pkg::SBM_LOAD;
      s_r.cfg <= sbm_pkg::sbm_cfg_t'(`SBM_CFG_RST);
      s_r.ien <= `SBM_IEN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  //============================================================
  // Outputs
  //============================================================

  // Comparator controls and system actions.
  always_comb begin
    reg_rdata = s_r.rdata;
    det_enable = s_r.cfg.enable &&
                 (s_r.fsm == sbm_pkg::SBM_CONT || s_r.fsm == sbm_pkg::SBM_ON);
    // Backup sleep or battery monitoring use the backup level.
    det_use_backup = backup_mode || s_r.cfg.monitor_select;
    det_level = det_use_backup ? s_r.cfg.backup_threshold_level : s_r.cfg.level;
    det_monitor_sel = s_r.cfg.monitor_select;
    // Core detector forced off in standby.
    core_det_enable = !standby_mode;
    // Brown-out reset by action, or core supply low.
    sys_reset_req = (s_r.det && s_r.cfg.brownout_action == sbm_pkg::SBM_ACT_RESET) ||
                    (core_below && core_det_enable);
    power_switch_req = s_r.psw;
    // One merged request from enabled flags.
    irq = |(s_r.flag & s_r.ien);
    cfg_loaded = (s_r.fsm != sbm_pkg::SBM_LOAD);
  end

  //============================================================
  // Checks
  //============================================================

  localparam int SMP_A = SAMPLE_CYC;

  // A newly raised enabled flag must reach the request pin on the next cycle.
  irq_merge_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (flag_set & s_r.ien) != 11'h000 && !wr_clr |=> irq) else $error("enabled flag without request");

  core_standby_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    standby_mode |-> !core_det_enable) else $error("core detector on in standby");

  core_reset_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    core_below && !standby_mode |-> sys_reset_req) else $error("core low without reset");

  en_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_clr |=> ({21'h0_0000, s_r.ien} & $past(reg_wdata)) == 32'h0000_0000) else $error("enable not cleared");

  act_reset_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_r.det && s_r.cfg.brownout_action == sbm_pkg::SBM_ACT_RESET |-> sys_reset_req)
    else $error("brown-out reset missing");

  bat_no_psw_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_r.cfg.monitor_select |-> !power_switch_req) else $error("switch on battery");

  load_cfg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_r.fsm == sbm_pkg::SBM_LOAD && nvm_valid |=> s_r.cfg == ($past(nvm_cfg) & `SBM_CFG_MASK))
    else $error("user row not loaded");

  sample_end_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(s_r.fsm == sbm_pkg::SBM_ON) |-> ##[1:SMP_A] s_r.fsm != sbm_pkg::SBM_ON)
    else $error("measure window too long");

  status_rd_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && hit(reg_addr, `SBM_OFS_STATUS) |=> reg_rdata[`SBM_IRQ_DET] == $past(s_r.det))
    else $error("status detection bit wrong");

  cont_on_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_r.cfg.enable && s_r.fsm == sbm_pkg::SBM_CONT |-> det_enable) else $error("continuous off");

  // The switch request only ever follows its own action on the main supply.
  psw_cond_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    power_switch_req |-> s_r.det && !s_r.cfg.monitor_select &&
    s_r.cfg.brownout_action == sbm_pkg::SBM_ACT_PSW) else $error("switch request without cause");

  // Only the six defined enable bits can ever be set.
  ien_mask_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s_r.ien & ~`SBM_IRQ_MASK) == 11'h000) else $error("reserved enable bit set");

  // A flag event in the same cycle as its clear leaves the flag set.
  flag_win_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_flag |=> (s_r.flag & $past(flag_set)) == $past(flag_set)) else $error("clear beat a new event");

  // A configuration write reports its crossing two cycles later.
  sync_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_cfg && s_r.fsm != sbm_pkg::SBM_LOAD |=> ##1 s_r.flag[`SBM_IRQ_SYNC_RDY])
    else $error("sync ready flag missing");

  // Continuous operation gives way to sampling on the next cycle.
  mode_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    sampling && s_r.fsm == sbm_pkg::SBM_CONT |=> s_r.fsm == sbm_pkg::SBM_OFF)
    else $error("sampling not entered");

  // Each prescaler edge short of the tick advances the divider by one.
  div_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    pre_rise && !tick |=> s_r.div == $past(s_r.div) + 17'h0_0001) else $error("divider skipped");

  // A disabled detector reports no brown-out.
  det_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !s_r.cfg.enable |=> !s_r.det) else $error("detection while disabled");

endmodule
`default_nettype wire

/* File: src/sbm_params.svh */
//==============================================================
// Overview of operation
// - Brown-out triggers interrupt, reset or power switch.
// - Backup sleep uses the backup threshold level.
// - Battery brown-out gives only interrupt or reset.
// - Detection result readable as brownout_detected status.
// - Configuration loaded from nonvolatile memory after reset.
// - Core comparator low forces a reset.
// - Core detector always off in standby.
// - Continuous monitoring is the default mode.
// - Enabled and sample bit clear means continuous.
// - Sampling enables detector briefly on each tick.
// - Sample bits select sampling per sleep mode.
// - Tick equals prescaler over two to psel+1.
// - Prescaler clock synchronised into bus clock.
// - Enable-clear writes of one clear enables.
// - Enable bits 10,9,8,2,1,0, all reset zero.
// - Enabled set flag raises interrupt request.
`ifndef SBM_PARAMS_SVH
`define SBM_PARAMS_SVH
// Register offsets on the plain register port.
`define SBM_OFS_IEN_CLR 8'h00
`define SBM_OFS_IEN_SET 8'h04
`define SBM_OFS_FLAG 8'h08
`define SBM_OFS_STATUS 8'h0C
`define SBM_OFS_CFG 8'h10
// Interrupt and status bit positions.
`define SBM_IRQ_BOD_RDY 0
`define SBM_IRQ_DET 1
`define SBM_IRQ_SYNC_RDY 2
`define SBM_IRQ_VREG_RDY 8
`define SBM_IRQ_APWS_RDY 9
`define SBM_IRQ_VCORE_RDY 10
`define SBM_IRQ_W 11
`define SBM_IRQ_MASK 11'h707
// Writable configuration bits and reset values.
`define SBM_CFG_MASK 32'h3F3F_F53A
`define SBM_CFG_RST 32'h0000_0000
`define SBM_IEN_RST 11'h000
// Timing: bus clock period and detector measure time.
`define SBM_CLK_PERIOD_NS 100
`define SBM_SAMPLE_TIME_NS 300
`define SBM_SAMPLE_CYC ((`SBM_SAMPLE_TIME_NS + `SBM_CLK_PERIOD_NS - 1) / `SBM_CLK_PERIOD_NS)
`define SBM_DIV_W 17
`endif

/* File: src/sbm_pkg.sv */
`include "sbm_params.svh"
package sbm_pkg;
  // Action taken when the supply drops below threshold.
  typedef enum logic [1:0] {
    SBM_ACT_NONE = 2'h0,
    SBM_ACT_INT = 2'h1,
    SBM_ACT_RESET = 2'h2,
    SBM_ACT_PSW = 2'h3
  } sbm_act_t;
  // Detector sequencing states, Gray along load-off-on.
  typedef enum logic [1:0] {
    SBM_LOAD = 2'b00,
    SBM_OFF = 2'b01,
    SBM_ON = 2'b11,
    SBM_CONT = 2'b10
  } sbm_fsm_t;
  // Configuration word layout of the detector register.
  typedef struct packed {
    logic [1:0] rsv3;
    logic [5:0] backup_threshold_level;
    logic [1:0] rsv2;
    logic [5:0] level;
    logic [3:0] sample_prescaler_select;
    logic rsv1;
    logic monitor_select;
    logic rsv0;
    logic active_sample_cfg;
    logic [1:0] rsvb;
    logic standby_sample_cfg;
    sbm_act_t brownout_action;
    logic rsva;
    logic enable;
    logic rsvz;
  } sbm_cfg_t;
  // Whole state of the controller.
  typedef struct packed {
    sbm_fsm_t fsm;
    sbm_cfg_t cfg;
    logic [`SBM_IRQ_W-1:0] ien;
    logic [`SBM_IRQ_W-1:0] flag;
    logic det;
    logic psw;
    logic [3:0] rdy_q;
    logic pre_s1;
    logic pre_s2;
    logic pre_q;
    logic [`SBM_DIV_W-1:0] div;
    logic [3:0] smp;
    logic srdy_p;
    logic [31:0] rdata;
  } sbm_st_t;
endpackage

/* File: test/sbm_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Behavioural main and core supply comparators.
module sbm_supply_model (
  // Clock.
  input wire logic sys_clk,
  // Controls from the block.
  input wire logic det_enable,
  input wire logic [5:0] det_level,
  input wire logic det_use_backup,
  input wire logic core_det_enable,
  // Supply codes set by the bench.
  input wire logic [5:0] vdd_code,
  input wire logic [5:0] vbat_code,
  input wire logic core_low,
  // Comparator outputs.
  output logic main_below,
  output logic main_ready,
  output logic core_below
);
  logic junk_r; // Moving pattern for an output with no valid answer.
  initial begin
    junk_r = 1'b0;
    main_ready = 1'b0;
  end
  // Ready lags enable by a cycle, as a settling comparator would.
  always @(posedge sys_clk) begin
    junk_r <= ~junk_r;
    main_ready <= det_enable;
  end
  // A disabled comparator says nothing useful, so it must not look stable.
  assign main_below = (det_enable && main_ready) ?
    ((det_use_backup ? vbat_code : vdd_code) < det_level) : junk_r;
  assign core_below = core_det_enable ? core_low : junk_r;
endmodule
`default_nettype wire

/* File: test/test_sbm_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbm_params.svh"
// ==========
// Compare macro; the mismatch line shows both values.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t: got %0h want %0h", $time, (g), (e)); end end
module test_sbm_ctrl;
  logic sys_clk, rstn, reg_wr, reg_rd, nvm_valid, standby_mode, backup_mode;
  logic prescaler_clk, main_below, main_ready, det_enable, det_use_backup;
  logic det_monitor_sel, core_below, core_det_enable, sys_reset_req;
  logic power_switch_req, irq, cfg_loaded, core_low, vc_rdy, ps_rdy, rg_rdy;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, nvm_cfg, v;
  logic [5:0] det_level, vdd, vbat;
  int err_total, n_checks, pdiv;
  // ==========
  // Clock and prescaler clock; the prescaler runs fast to keep the run short.
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    pdiv <= (pdiv == 19) ? 0 : pdiv + 1;
    if (pdiv == 19) begin
      prescaler_clk <= ~prescaler_clk;
    end
  end
  sbm_ctrl #(.SAMPLE_CYC(3)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nvm_cfg(nvm_cfg), .nvm_valid(nvm_valid), .standby_mode(standby_mode),
    .backup_mode(backup_mode), .prescaler_clk(prescaler_clk), .main_below(main_below),
    .main_ready(main_ready), .det_enable(det_enable), .det_level(det_level),
    .det_use_backup(det_use_backup), .det_monitor_sel(det_monitor_sel),
    .core_below(core_below), .core_voltage_ready_in(vc_rdy), .power_switch_ready_in(ps_rdy),
    .regulator_ready_in(rg_rdy), .core_det_enable(core_det_enable),
    .sys_reset_req(sys_reset_req), .power_switch_req(power_switch_req), .irq(irq),
    .cfg_loaded(cfg_loaded));
  sbm_supply_model model_u (.sys_clk(sys_clk), .det_enable(det_enable), .det_level(det_level),
    .det_use_backup(det_use_backup), .core_det_enable(core_det_enable), .vdd_code(vdd),
    .vbat_code(vbat), .core_low(core_low), .main_below(main_below), .main_ready(main_ready),
    .core_below(core_below));
  // ==========
  // Verdict and end of run.
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Register bus: one-cycle strobes, read data in the following cycle only.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait for the detector enable to reach a level; counts cycles.
  task automatic wait_en(input logic lvl, output int n);
    n = 0;
    while (det_enable !== lvl) begin
      cyc(1);
      n++;
      if (n > 2000) begin
        err_total++;
        $display("MISMATCH %0t: wait ran out", $time);
        results();
      end
    end
  endtask
  // ==========
  // Scenarios.
  task automatic t_reset();
    `CHK(cfg_loaded, 1'b0)
    cyc(3);
    `CHK(cfg_loaded, 1'b1)
    rd(`SBM_OFS_CFG, v);
    `CHK(v, 32'h0010_0012)
    cyc(1);
    `CHK(reg_rdata, 32'h0000_0000)
    rd(`SBM_OFS_IEN_CLR, v);
    `CHK(v, 32'h0000_0000)
    rd(8'h20, v);
    `CHK(v, 32'h0000_0000)
    `CHK(det_enable, 1'b1)
    $display("Test reset done");
  endtask
  task automatic t_cont();
    @(posedge sys_clk) vdd <= 6'h08;
    cyc(4);
    `CHK(sys_reset_req, 1'b1)
    `CHK(det_enable, 1'b1)
    rd(`SBM_OFS_STATUS, v);
    `CHK(v[1], 1'b1)
    @(posedge sys_clk) vdd <= 6'h20;
    cyc(4);
    `CHK(sys_reset_req, 1'b0)
    $display("Test continuous done");
  endtask
  task automatic t_irq();
    wr(`SBM_OFS_FLAG, 32'h0000_0707);
    wr(`SBM_OFS_CFG, 32'h0010_000A);
    wr(`SBM_OFS_IEN_SET, 32'h0000_0002);
    cyc(2);
    `CHK(irq, 1'b0)
    @(posedge sys_clk) vdd <= 6'h08;
    cyc(4);
    `CHK(irq, 1'b1)
    `CHK(sys_reset_req, 1'b0)
    wr(`SBM_OFS_IEN_CLR, 32'h0000_0002);
    cyc(1);
    `CHK(irq, 1'b0)
    rd(`SBM_OFS_IEN_SET, v);
    `CHK(v, 32'h0000_0000)
    @(posedge sys_clk) vdd <= 6'h20;
    wr(`SBM_OFS_IEN_SET, 32'h0000_0700);
    @(posedge sys_clk) rg_rdy <= 1'b1;
    cyc(3);
    `CHK(irq, 1'b1)
    rd(`SBM_OFS_IEN_CLR, v);
    `CHK(v, 32'h0000_0700)
    wr(`SBM_OFS_IEN_CLR, 32'h0000_0100);
    rd(`SBM_OFS_IEN_SET, v);
    `CHK(v, 32'h0000_0600)
    `CHK(irq, 1'b0)
    @(posedge sys_clk) ps_rdy <= 1'b1;
    vc_rdy <= 1'b1;
    cyc(3);
    `CHK(irq, 1'b1)
    rd(`SBM_OFS_FLAG, v);
    `CHK(v, 32'h0000_0706)
    $display("Test interrupt done");
  endtask
  task automatic t_psw();
    @(posedge sys_clk) vdd <= 6'h08;
    wr(`SBM_OFS_CFG, 32'h0010_001A);
    cyc(4);
    `CHK(power_switch_req, 1'b1)
    @(posedge sys_clk) vbat <= 6'h08;
    wr(`SBM_OFS_CFG, 32'h1010_041A);
    cyc(6);
    `CHK(power_switch_req, 1'b0)
    `CHK(det_use_backup, 1'b1)
    `CHK(det_monitor_sel, 1'b1)
    rd(`SBM_OFS_STATUS, v);
    `CHK(v[1], 1'b1)
    wr(`SBM_OFS_CFG, 32'h1010_0412);
    cyc(4);
    `CHK(sys_reset_req, 1'b1)
    @(posedge sys_clk) vdd <= 6'h20;
    wr(`SBM_OFS_CFG, 32'h1410_0002);
    @(posedge sys_clk) backup_mode <= 1'b1;
    cyc(3);
    `CHK(det_level, 6'h14)
    `CHK(det_use_backup, 1'b1)
    @(posedge sys_clk) backup_mode <= 1'b0;
    cyc(3);
    `CHK(det_level, 6'h10)
    $display("Test action done");
  endtask
  // Sampling period and on-time; the first pulse after a write may be partial.
  task automatic t_sample(input logic [31:0] c, input logic sb, input int gap);
    int a, w, b;
    @(posedge sys_clk) standby_mode <= sb;
    wr(`SBM_OFS_CFG, c);
    wait_en(1'b0, a);
    wait_en(1'b1, a);
    wait_en(1'b0, w);
    wait_en(1'b1, b);
    `CHK(w, 3)
    `CHK(w + b, gap)
    if (sb) begin
      `CHK(core_det_enable, 1'b0)
      @(posedge sys_clk) core_low <= 1'b1;
      cyc(3);
      `CHK(sys_reset_req, 1'b0)
      @(posedge sys_clk) standby_mode <= 1'b0;
      cyc(4);
      `CHK(sys_reset_req, 1'b1)
      `CHK(det_enable, 1'b1)
      @(posedge sys_clk) core_low <= 1'b0;
    end
    $display("Test sampling done");
  endtask
  // A second reset mid-run clears the block and reloads the user row.
  task automatic t_reload();
    @(posedge sys_clk) rstn <= 1'b0;
    cyc(2);
    `CHK(cfg_loaded, 1'b0)
    `CHK(irq, 1'b0)
    `CHK(power_switch_req, 1'b0)
    @(posedge sys_clk) rstn <= 1'b1;
    cyc(2);
    `CHK(cfg_loaded, 1'b1)
    rd(`SBM_OFS_CFG, v);
    `CHK(v, 32'h0010_0012)
    $display("Test reload done");
  endtask
  // ==========
  // Main sequence.
  initial begin
    sys_clk = 0;
    rstn = 0;
    reg_addr = 0;
    reg_wdata = 0;
    reg_wr = 0;
    reg_rd = 0;
    nvm_cfg = 32'hC010_0012;
    nvm_valid = 0;
    standby_mode = 0;
    backup_mode = 0;
    prescaler_clk = 0;
    pdiv = 0;
    vdd = 6'h20;
    vbat = 6'h20;
    core_low = 0;
    vc_rdy = 0;
    ps_rdy = 0;
    rg_rdy = 0;
    err_total = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    nvm_valid <= 1'b1;
    #1;
    t_reset();
    t_cont();
    t_irq();
    t_psw();
    t_sample(32'h0010_0102, 1'b0, 80);
    t_sample(32'h0010_1102, 1'b0, 160);
    t_sample(32'h0010_0022, 1'b1, 80);
    t_reload();
    results();
  end
endmodule
`default_nettype wire
